// ---- hw/pms_defs.svh ----
// Purpose: Constants for the power mode sequencer
// Assumes: 40 MHz MCLK
// Notes:   Field codes and timing counts as macros
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

`define PMS_REGULATOR_FREQUENCY_FIELD_W          2
`define PMS_REGULATOR_FREQUENCY_FIELD_OFF        2'h0
`define PMS_REGULATOR_FREQUENCY_FIELD_RST        2'h3
`define PMS_PERIPH_N        8
`define PMS_CLK_PERIOD_NS   25
`define PMS_SWITCH_NS       200
`define PMS_SWITCH_CYC      (((`PMS_SWITCH_NS) + (`PMS_CLK_PERIOD_NS) - 1) / (`PMS_CLK_PERIOD_NS))
`define PMS_CNT_W           4
`define PMS_WAKE_N          8

`endif

// ---- hw/pms_pkg.sv ----
// Purpose: Types for the power mode sequencer
// Assumes: Included constants header
// Notes:   Mode enum and clock/power control struct
package pms_pkg;
    typedef enum logic [2:0] {
        PMS_FULL_ON,
        PMS_ACTIVE,
        PMS_SLEEP,
        PMS_DEEP_SLEEP,
        PMS_HIBERNATE
    } pms_mode_e;

    typedef struct packed {
        logic pll_enable;
        logic pll_bypass;
        logic core_clk_en;
        logic sys_clk_en;
        logic core_power;
    } pms_ctl_s;
endpackage

// ---- hw/pms_sync.sv ----
// Purpose: Three-flop input synchroniser with agreement filter
// Assumes: Asynchronous pin inputs
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pms_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    logic out_next;

    always_comb begin
        out_next = out_reg;
        if (s2_reg == s3_reg) begin
            out_next = s3_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            s1_reg  <= din;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule
`default_nettype wire

// ---- hw/pms_gate.sv ----
// Purpose: Per-peripheral clock enable register bank
// Assumes: Enables qualified by the system clock enable
// Notes:   One flop per peripheral, generate loop
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.svh"
module pms_gate (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic [`PMS_PERIPH_N-1:0]  gate_on,
    input  wire logic                      sys_clk_en,
    output logic      [`PMS_PERIPH_N-1:0]  periph_clk_en
);
    genvar i;
    generate
        for (i = 0; i < `PMS_PERIPH_N; i = i + 1) begin : g_gate
            logic en_reg;
            logic en_next;
            always_comb begin
                en_next = gate_on[i] & sys_clk_en;
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    en_reg <= 1'b0;
                end else begin
                    en_reg <= en_next;
                end
            end
            assign periph_clk_en[i] = en_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- hw/pms_top.sv ----
// Purpose: Power mode sequencer: operating modes, wakeup, hibernate
// Assumes: MCLK 40 MHz, RST_N async active low; regulator reg kept on I/O supply
// Notes:   Control bits are plain ports
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.svh"
module pms_top (
    input  wire logic                      MCLK,
    input  wire logic                      RST_N,
    input  wire logic                      REG_RST_N,
    input  wire logic                      RESET_PIN_N,
    input  wire logic                      MODE_REQ,
    input  wire logic [2:0]                MODE_SEL,
    input  wire logic                      PLL_ENABLE_WR,
    input  wire logic                      PLL_ENABLE_IN,
    input  wire logic                      PLL_BYPASS_WR,
    input  wire logic                      PLL_BYPASS_IN,
    input  wire logic                      REGULATOR_FREQUENCY_FIELD_WR,
    input  wire logic [`PMS_REGULATOR_FREQUENCY_FIELD_W-1:0]    REGULATOR_FREQUENCY_FIELD_IN,
    input  wire logic [`PMS_WAKE_N-1:0]    WAKE_ENABLE,
    input  wire logic [`PMS_WAKE_N-1:0]    WAKE_EVENT,
    input  wire logic                      RTC_IRQ,
    input  wire logic                      HIB_WAKE,
    input  wire logic [`PMS_PERIPH_N-1:0]  PERIPH_GATE_ON,
    output logic                           PLL_ENABLE,
    output logic                           PLL_BYPASS,
    output logic                           CORE_CLK_EN,
    output logic                           SYS_CLK_EN,
    output logic                           CORE_POWER,
    output logic [`PMS_PERIPH_N-1:0]       PERIPH_CLK_EN,
    output logic                           DMA_L1_GRANT,
    output logic                           ASYNC_ACCESS_EN,
    output logic                           PIN_OUTPUT_EN,
    output logic                           EXTERNAL_WAKE_OUT_A,
    output logic                           EXTERNAL_WAKE_OUT_B,
    output logic                           HW_RESET_REQ,
    output logic                           BUSY,
    output logic [2:0]                     MODE
);
    pms_pkg::pms_mode_e                    mode_reg;
    pms_pkg::pms_mode_e                    mode_next;
    pms_pkg::pms_mode_e                    target_reg;
    pms_pkg::pms_mode_e                    target_next;
    logic                                  busy_reg;
    logic                                  busy_next;
    logic [`PMS_CNT_W-1:0]                 cnt_reg;
    logic [`PMS_CNT_W-1:0]                 cnt_next;
    logic                                  pll_en_reg;
    logic                                  pll_en_next;
    logic                                  bypass_reg;
    logic                                  bypass_next;
    logic                                  rst_req_reg;
    logic                                  rst_req_next;
    pms_pkg::pms_ctl_s                     ctl_reg;
    pms_pkg::pms_ctl_s                     ctl_next;
    logic                                  dma_reg;
    logic                                  dma_next;
    logic                                  async_reg;
    logic                                  async_next;
    logic                                  pin_en_reg;
    logic                                  pin_en_next;
    logic [`PMS_REGULATOR_FREQUENCY_FIELD_W-1:0]                regulator_frequency_field_reg;
    logic [`PMS_REGULATOR_FREQUENCY_FIELD_W-1:0]                regulator_frequency_field_next;
    logic                                  wake_a_reg;
    logic                                  wake_b_reg;
    logic                                  wake_next;
    logic                                  reset_pin_n_s;
    logic                                  rtc_s;
    logic                                  hib_wake_s;
    logic                                  wake_hit;

    // Pin is inverted so a held reset reads as a wake level
    pms_sync u_sync_rst (
        .clk   (MCLK),
        .rst_n (RST_N),
        .din   (~RESET_PIN_N),
        .dout  (reset_pin_n_s)
    );

    pms_sync u_sync_rtc (
        .clk   (MCLK),
        .rst_n (RST_N),
        .din   (RTC_IRQ),
        .dout  (rtc_s)
    );

    pms_sync u_sync_hib (
        .clk   (MCLK),
        .rst_n (RST_N),
        .din   (HIB_WAKE),
        .dout  (hib_wake_s)
    );

    assign wake_hit = |(WAKE_ENABLE & WAKE_EVENT);

    // Zero frequency code shuts the core regulator down
    function automatic logic regulator_frequency_field_is_off(input logic [`PMS_REGULATOR_FREQUENCY_FIELD_W-1:0] f);
        return (f == `PMS_REGULATOR_FREQUENCY_FIELD_OFF);
    endfunction

    // Per-mode clock and power settings
    function automatic pms_pkg::pms_ctl_s mode_ctl(input pms_pkg::pms_mode_e m,
                                                   input logic pll_on);
        pms_pkg::pms_ctl_s c;
        c = '0;
        unique case (m)
            pms_pkg::PMS_FULL_ON: begin
                c = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            end
            pms_pkg::PMS_ACTIVE: begin
                c = '{pll_on, 1'b1, 1'b1, 1'b1, 1'b1};
            end
            pms_pkg::PMS_SLEEP: begin
                c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
            end
            pms_pkg::PMS_DEEP_SLEEP: begin
                c = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            end
            pms_pkg::PMS_HIBERNATE: begin
                c = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
            end
            default: begin
                c = '0;
            end
        endcase
        return c;
    endfunction

    // Mode sequencing; when idle the priority is hibernate wake,
    // regulator off, deep sleep exit, sleep wake, then a mode request
    always_comb begin
        mode_next    = mode_reg;
        target_next  = target_reg;
        busy_next    = busy_reg;
        cnt_next     = cnt_reg;
        pll_en_next  = pll_en_reg;
        bypass_next  = bypass_reg;
        rst_req_next = 1'b0;
        regulator_frequency_field_next    = regulator_frequency_field_reg;
        // PLL enable may only be written in active mode
        if (PLL_ENABLE_WR && mode_reg == pms_pkg::PMS_ACTIVE) begin
            pll_en_next = PLL_ENABLE_IN;
        end
        if (PLL_BYPASS_WR) begin
            bypass_next = PLL_BYPASS_IN;
        end
        // Regulator writes are dropped during a switch so wake outputs track the mode
        if (REGULATOR_FREQUENCY_FIELD_WR && !busy_reg) begin
            regulator_frequency_field_next = REGULATOR_FREQUENCY_FIELD_IN;
        end
        if (busy_reg) begin
            // Count down the clock switch, then commit the mode
            if (cnt_reg == '0) begin
                busy_next = 1'b0;
                mode_next = target_reg;
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
        end else if (mode_reg == pms_pkg::PMS_HIBERNATE) begin
            // A hibernate wake, RTC or reset pin restarts from reset with the regulator back on
            // and the PLL settings of full-on
            if (hib_wake_s || rtc_s || reset_pin_n_s) begin
                rst_req_next = 1'b1;
                pll_en_next  = 1'b1;
                bypass_next  = 1'b0;
                regulator_frequency_field_next    = `PMS_REGULATOR_FREQUENCY_FIELD_RST;
                target_next  = pms_pkg::PMS_FULL_ON;
                busy_next    = 1'b1;
                cnt_next     = `PMS_CNT_W'(`PMS_SWITCH_CYC);
            end
        end else if (REGULATOR_FREQUENCY_FIELD_WR && regulator_frequency_field_is_off(REGULATOR_FREQUENCY_FIELD_IN)) begin
            target_next = pms_pkg::PMS_HIBERNATE;
            busy_next   = 1'b1;
            cnt_next    = `PMS_CNT_W'(`PMS_SWITCH_CYC);
        end else if (mode_reg == pms_pkg::PMS_DEEP_SLEEP) begin
            // Besides a regulator-off write, only the reset pin or the RTC leaves deep sleep
            if (reset_pin_n_s) begin
                target_next = pms_pkg::PMS_FULL_ON;
                pll_en_next = 1'b1;
                bypass_next = 1'b0;
                busy_next   = 1'b1;
                cnt_next    = `PMS_CNT_W'(`PMS_SWITCH_CYC);
            end else if (rtc_s) begin
                target_next = pms_pkg::PMS_ACTIVE;
                busy_next   = 1'b1;
                cnt_next    = `PMS_CNT_W'(`PMS_SWITCH_CYC);
            end
        end else if (mode_reg == pms_pkg::PMS_SLEEP && wake_hit) begin
            target_next = bypass_reg ? pms_pkg::PMS_ACTIVE : pms_pkg::PMS_FULL_ON;
            busy_next   = 1'b1;
            cnt_next    = `PMS_CNT_W'(`PMS_SWITCH_CYC);
        end else if (MODE_REQ && MODE_SEL <= 3'h3) begin
            target_next = pms_pkg::pms_mode_e'(MODE_SEL);
            busy_next   = 1'b1;
            cnt_next    = `PMS_CNT_W'(`PMS_SWITCH_CYC);
        end
    end

    // Outputs derived from the committed mode; wake outputs from the regulator field
    always_comb begin
        ctl_next    = mode_ctl(mode_next, pll_en_next);
        dma_next    = (mode_next == pms_pkg::PMS_FULL_ON)
                   || (mode_next == pms_pkg::PMS_ACTIVE);
        async_next  = (mode_next != pms_pkg::PMS_DEEP_SLEEP)
                   && (mode_next != pms_pkg::PMS_HIBERNATE);
        pin_en_next = (mode_next != pms_pkg::PMS_HIBERNATE);
        wake_next   = !regulator_frequency_field_is_off(regulator_frequency_field_next);
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_reg    <= pms_pkg::PMS_FULL_ON;
            target_reg  <= pms_pkg::PMS_FULL_ON;
            busy_reg    <= 1'b0;
            cnt_reg     <= '0;
            pll_en_reg  <= 1'b1;
            bypass_reg  <= 1'b0;
            rst_req_reg <= 1'b0;
            ctl_reg     <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            dma_reg     <= 1'b1;
            async_reg   <= 1'b1;
            pin_en_reg  <= 1'b1;
        end else begin
            mode_reg    <= mode_next;
            target_reg  <= target_next;
            busy_reg    <= busy_next;
            cnt_reg     <= cnt_next;
            pll_en_reg  <= pll_en_next;
            bypass_reg  <= bypass_next;
            rst_req_reg <= rst_req_next;
            ctl_reg     <= ctl_next;
            dma_reg     <= dma_next;
            async_reg   <= async_next;
            pin_en_reg  <= pin_en_next;
        end
    end

    // Regulator field on its own reset so it survives hibernate
    always_ff @(posedge MCLK or negedge REG_RST_N) begin
        if (!REG_RST_N) begin
            regulator_frequency_field_reg   <= `PMS_REGULATOR_FREQUENCY_FIELD_RST;
            wake_a_reg <= 1'b1;
            wake_b_reg <= 1'b1;
        end else begin
            regulator_frequency_field_reg   <= regulator_frequency_field_next;
            wake_a_reg <= wake_next;
            wake_b_reg <= wake_next;
        end
    end

    // Peripheral enables lag the system clock enable by one cycle
    pms_gate u_gate (
        .clk           (MCLK),
        .rst_n         (RST_N),
        .gate_on       (PERIPH_GATE_ON),
        .sys_clk_en    (ctl_reg.sys_clk_en),
        .periph_clk_en (PERIPH_CLK_EN)
    );

    assign PLL_ENABLE          = ctl_reg.pll_enable;
    assign PLL_BYPASS          = ctl_reg.pll_bypass;
    assign CORE_CLK_EN         = ctl_reg.core_clk_en;
    assign SYS_CLK_EN          = ctl_reg.sys_clk_en;
    assign CORE_POWER          = ctl_reg.core_power;
    assign DMA_L1_GRANT        = dma_reg;
    assign ASYNC_ACCESS_EN     = async_reg;
    assign PIN_OUTPUT_EN       = pin_en_reg;
    assign EXTERNAL_WAKE_OUT_A = wake_a_reg;
    assign EXTERNAL_WAKE_OUT_B = wake_b_reg;
    assign HW_RESET_REQ        = rst_req_reg;
    assign BUSY                = busy_reg;
    assign MODE                = mode_reg;
endmodule
`default_nettype wire

// ---- verif/pms_chk.sv ----
// Purpose: Port assertions for the power mode sequencer
// Assumes: Bound to pms_top, single MCLK domain
// Notes:   Mode settings checked whenever the mode register holds them, full-on only when not busy
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.svh"
module pms_chk (
    input wire logic                      MCLK,
    input wire logic                      RST_N,
    input wire logic                      REGULATOR_FREQUENCY_FIELD_WR,
    input wire logic [`PMS_REGULATOR_FREQUENCY_FIELD_W-1:0]    REGULATOR_FREQUENCY_FIELD_IN,
    input wire logic [`PMS_PERIPH_N-1:0]  PERIPH_GATE_ON,
    input wire logic                      PLL_ENABLE,
    input wire logic                      PLL_BYPASS,
    input wire logic                      CORE_CLK_EN,
    input wire logic                      SYS_CLK_EN,
    input wire logic                      CORE_POWER,
    input wire logic [`PMS_PERIPH_N-1:0]  PERIPH_CLK_EN,
    input wire logic                      DMA_L1_GRANT,
    input wire logic                      ASYNC_ACCESS_EN,
    input wire logic                      PIN_OUTPUT_EN,
    input wire logic                      EXTERNAL_WAKE_OUT_A,
    input wire logic                      EXTERNAL_WAKE_OUT_B,
    input wire logic                      HW_RESET_REQ,
    input wire logic                      BUSY,
    input wire logic [2:0]                MODE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic [3:0] busy_len;
    // Counts busy cycles of the switch in progress
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_len <= 4'h0;
        end else begin
            busy_len <= BUSY ? busy_len + 4'h1 : 4'h0;
        end
    end
    sequence s_switch_done;
        !BUSY && busy_len == 4'(`PMS_SWITCH_CYC + 1);
    endsequence
    a_switch_time: assert property ($fell(BUSY) |-> s_switch_done)
        else $error("busy span wrong");
    a_busy_bound: assert property (BUSY |-> busy_len <= 4'(`PMS_SWITCH_CYC))
        else $error("busy lasts too long");
    a_mode_done: assert property ($changed(MODE) |-> $fell(BUSY))
        else $error("mode changed outside a finished switch");
    a_full_ctl: assert property (MODE == pms_pkg::PMS_FULL_ON && !BUSY |-> PLL_ENABLE
        && !PLL_BYPASS && CORE_CLK_EN && SYS_CLK_EN && CORE_POWER && DMA_L1_GRANT)
        else $error("full-on settings wrong");
    a_active_ctl: assert property (MODE == pms_pkg::PMS_ACTIVE |-> PLL_BYPASS
        && CORE_CLK_EN && SYS_CLK_EN && CORE_POWER && DMA_L1_GRANT)
        else $error("active settings wrong");
    a_sleep_ctl: assert property (MODE == pms_pkg::PMS_SLEEP |-> PLL_ENABLE
        && !CORE_CLK_EN && SYS_CLK_EN && CORE_POWER && !DMA_L1_GRANT)
        else $error("sleep settings wrong");
    a_deep_ctl: assert property (MODE == pms_pkg::PMS_DEEP_SLEEP |-> !PLL_ENABLE
        && !CORE_CLK_EN && !SYS_CLK_EN && CORE_POWER && !ASYNC_ACCESS_EN)
        else $error("deep sleep settings wrong");
    a_hib_ctl: assert property (MODE == pms_pkg::PMS_HIBERNATE |-> !PLL_ENABLE
        && !CORE_CLK_EN && !SYS_CLK_EN && !CORE_POWER && !PIN_OUTPUT_EN)
        else $error("hibernate settings wrong");
    a_regulator_frequency_field_zero: assert property (REGULATOR_FREQUENCY_FIELD_WR && REGULATOR_FREQUENCY_FIELD_IN == `PMS_REGULATOR_FREQUENCY_FIELD_OFF && !BUSY
        && MODE != pms_pkg::PMS_HIBERNATE |=> !EXTERNAL_WAKE_OUT_A && !EXTERNAL_WAKE_OUT_B)
        else $error("wake outputs not dropped");
    a_periph_gate: assert property ($past(RST_N) |-> PERIPH_CLK_EN ==
        ($past(PERIPH_GATE_ON) & {`PMS_PERIPH_N{$past(SYS_CLK_EN)}}))
        else $error("peripheral clock enable wrong");
    a_reset_pulse: assert property (HW_RESET_REQ |=> !HW_RESET_REQ)
        else $error("reset request longer than one cycle");
endmodule
bind pms_top pms_chk u_chk (.*);
`default_nettype wire

// ---- verif/pms_wake_model.sv ----
// Purpose: Wakeup sources and external regulator beside the sequencer
// Assumes: Fire strobes come from the bench for one cycle
// Notes:   Async sources hold their level long enough for the synchroniser
`timescale 1ns/1ps
`default_nettype none
module pms_wake_model (
    input  wire logic MCLK,
    input  wire logic ext_wake_a,
    input  wire logic ext_wake_b,
    input  wire logic rtc_fire,
    input  wire logic hib_fire,
    output logic      rtc_irq,
    output logic      hib_wake,
    output logic      supply_up
);
    logic [3:0] rtc_cnt = 4'h0;
    logic [3:0] hib_cnt = 4'h0;
    always @(posedge MCLK) begin
        rtc_cnt <= rtc_fire ? 4'h6 : (rtc_cnt != 4'h0 ? rtc_cnt - 4'h1 : 4'h0);
        hib_cnt <= hib_fire ? 4'h6 : (hib_cnt != 4'h0 ? hib_cnt - 4'h1 : 4'h0);
    end
    assign rtc_irq  = rtc_cnt != 4'h0;
    assign hib_wake = hib_cnt != 4'h0;
    // Regulator keeps the core supplied while either wake line is high
    assign supply_up = ext_wake_a | ext_wake_b;
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the power mode sequencer
// Assumes: Inputs driven on the falling edge of MCLK
// Notes:   Switching scenarios wait on BUSY under a bounded count; the hibernate wake waits a fixed 40 cycles
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.svh"
module tb;
    logic MCLK = 0, RST_N = 0, REG_RST_N = 0, RESET_PIN_N = 1, MODE_REQ = 0;
    logic [2:0] MODE_SEL = 3'h0;
    logic PLL_ENABLE_WR = 0, PLL_ENABLE_IN = 1, PLL_BYPASS_WR = 0, PLL_BYPASS_IN = 0;
    logic REGULATOR_FREQUENCY_FIELD_WR = 0, RTC_IRQ, HIB_WAKE, rtc_fire = 0, hib_fire = 0, supply_up;
    logic [1:0] REGULATOR_FREQUENCY_FIELD_IN = 2'h3;
    logic [7:0] WAKE_ENABLE = 8'h04, WAKE_EVENT = 8'h00, PERIPH_GATE_ON = 8'hA5;
    logic PLL_ENABLE, PLL_BYPASS, CORE_CLK_EN, SYS_CLK_EN, CORE_POWER, DMA_L1_GRANT;
    logic ASYNC_ACCESS_EN, PIN_OUTPUT_EN, EXTERNAL_WAKE_OUT_A, EXTERNAL_WAKE_OUT_B;
    logic HW_RESET_REQ, BUSY;
    logic [7:0] PERIPH_CLK_EN;
    logic [2:0] MODE;
    int n_errors = 0, num_checks = 0;
    pms_top u_pms_top (.*);
    pms_wake_model u_pms_wake_model (.MCLK(MCLK), .ext_wake_a(EXTERNAL_WAKE_OUT_A),
        .ext_wake_b(EXTERNAL_WAKE_OUT_B), .rtc_fire(rtc_fire), .hib_fire(hib_fire),
        .rtc_irq(RTC_IRQ), .hib_wake(HIB_WAKE), .supply_up(supply_up));
    always #12.5 MCLK = ~MCLK;
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t %s", $time, what);
        end
    endtask
    // Expected settings, with a mask for fields that the mode leaves free
    task automatic chk_mode(input pms_pkg::pms_mode_e m, input logic [4:0] c, input logic [4:0] k);
        logic [4:0] got;
        got = {PLL_ENABLE, PLL_BYPASS, CORE_CLK_EN, SYS_CLK_EN, CORE_POWER};
        chk1(MODE === m && (got & k) === (c & k), 1'b1, "mode or settings");
    endtask
    task automatic run_to_idle();
        int i;
        logic seen;
        seen = 0;
        for (i = 0; i < 40; i++) begin
            @(negedge MCLK);
            if (BUSY === 1'b1) seen = 1;
            else if (seen) break;
        end
        chk1(seen && BUSY === 1'b0, 1'b1, "switch did not finish");
    endtask
    task automatic req(input logic [2:0] sel);
        @(negedge MCLK);
        MODE_SEL = sel;
        MODE_REQ = 1;
        @(negedge MCLK);
        MODE_REQ = 0;
        run_to_idle();
    endtask
    task automatic set_bypass(input logic b);
        @(negedge MCLK);
        PLL_BYPASS_WR = 1;
        PLL_BYPASS_IN = b;
        @(negedge MCLK);
        PLL_BYPASS_WR = 0;
    endtask
    task automatic t_reset();
        chk_mode(pms_pkg::PMS_FULL_ON, 5'h17, 5'h1F);
        chk1(PERIPH_CLK_EN === 8'hA5 && PIN_OUTPUT_EN === 1'b1, 1'b1, "gates");
        PERIPH_GATE_ON = 8'h5A;
        repeat (2) @(negedge MCLK);
        chk1(PERIPH_CLK_EN === 8'h5A, 1'b1, "gate change");
    endtask
    task automatic t_sleep(input logic b);
        set_bypass(b);
        req(3'h2);
        chk_mode(pms_pkg::PMS_SLEEP, 5'h13, 5'h17);
        chk1(DMA_L1_GRANT, 1'b0, "sleep dma");
        WAKE_EVENT = 8'h01;
        repeat (20) @(negedge MCLK);
        chk1(BUSY === 1'b0 && MODE === 3'h2, 1'b1, "masked wake taken");
        WAKE_EVENT = 8'h04;
        run_to_idle();
        WAKE_EVENT = 8'h00;
        if (b) chk_mode(pms_pkg::PMS_ACTIVE, 5'h0F, 5'h0F);
        else chk_mode(pms_pkg::PMS_FULL_ON, 5'h17, 5'h1F);
        chk1(DMA_L1_GRANT, 1'b1, "dma after wake");
    endtask
    task automatic t_pll(input logic v);
        @(negedge MCLK);
        PLL_ENABLE_WR = 1;
        PLL_ENABLE_IN = v;
        @(negedge MCLK);
        PLL_ENABLE_WR = 0;
        @(negedge MCLK);
        chk1(PLL_ENABLE, v, "pll enable write");
    endtask
    task automatic t_refuse();
        @(negedge MCLK);
        MODE_SEL = 3'h5;
        MODE_REQ = 1;
        @(negedge MCLK);
        MODE_REQ = 0;
        repeat (15) @(negedge MCLK);
        chk1(BUSY === 1'b0 && MODE === 3'h0, 1'b1, "bad select taken");
        MODE_SEL = 3'h1;
        MODE_REQ = 1;
        @(negedge MCLK);
        MODE_REQ = 0;
        repeat (3) @(negedge MCLK);
        MODE_SEL = 3'h3;
        MODE_REQ = 1;
        @(negedge MCLK);
        MODE_REQ = 0;
        run_to_idle();
        repeat (5) @(negedge MCLK);
        chk1(BUSY === 1'b0 && MODE === 3'h1, 1'b1, "request during switch");
    endtask
    task automatic t_deep(input logic by_pin);
        req(3'h3);
        chk_mode(pms_pkg::PMS_DEEP_SLEEP, 5'h01, 5'h17);
        @(negedge MCLK);
        chk1(ASYNC_ACCESS_EN === 1'b0 && PERIPH_CLK_EN === 8'h00, 1'b1, "deep");
        @(negedge MCLK);
        if (by_pin) RESET_PIN_N = 0;
        else rtc_fire = 1;
        @(negedge MCLK);
        rtc_fire = 0;
        run_to_idle();
        RESET_PIN_N = 1;
        if (by_pin) chk_mode(pms_pkg::PMS_FULL_ON, 5'h17, 5'h1F);
        else chk_mode(pms_pkg::PMS_ACTIVE, 5'h0F, 5'h0F);
    endtask
    task automatic t_hib();
        int pulses;
        pulses = 0;
        // Bench holds no state that must outlive the power cut
        @(negedge MCLK);
        REGULATOR_FREQUENCY_FIELD_WR = 1;
        REGULATOR_FREQUENCY_FIELD_IN = 2'h0;
        @(negedge MCLK);
        REGULATOR_FREQUENCY_FIELD_WR = 0;
        @(negedge MCLK);
        chk1(EXTERNAL_WAKE_OUT_A | EXTERNAL_WAKE_OUT_B, 1'b0, "wake outs");
        chk1(supply_up, 1'b0, "regulator still on");
        run_to_idle();
        chk_mode(pms_pkg::PMS_HIBERNATE, 5'h00, 5'h17);
        chk1(PIN_OUTPUT_EN, 1'b0, "pins driven");
        hib_fire = 1;
        @(negedge MCLK);
        hib_fire = 0;
        repeat (40) begin
            @(negedge MCLK);
            if (HW_RESET_REQ === 1'b1) pulses++;
        end
        chk1(pulses == 1, 1'b1, "reset request count");
        chk_mode(pms_pkg::PMS_FULL_ON, 5'h17, 5'h1F);
        chk1(EXTERNAL_WAKE_OUT_A & EXTERNAL_WAKE_OUT_B, 1'b1, "wake outs high");
    endtask
    initial begin
        #(25 * 4000);
        n_errors++;
        $display("mismatch %0t watchdog expired", $time);
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge MCLK);
        @(negedge MCLK);
        RST_N = 1;
        REG_RST_N = 1;
        @(negedge MCLK);
        t_reset();
        t_refuse();
        set_bypass(1'b0);
        req(3'h0);
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_pll(1'b0);
        t_pll(1'b1);
        t_deep(1'b0);
        t_deep(1'b1);
        t_hib();
        wrap_up();
    end
endmodule
`default_nettype wire
